/* uiecs_pkg.sv */
`default_nettype none
package uiecs_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] REG_INDEX_IDX = 8'h0e;
    localparam logic [7:0] REG_CTRL_LOW_IDX = 8'h11;
    localparam logic [7:0] REG_CTRL_HIGH_IDX = 8'h12;
    localparam logic [7:0] REG_IRQ_STATUS_IDX = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK_IDX = 8'h21;
    localparam logic [7:0] REG_ISO_CFG_IDX = 8'h22;

    // in_endpoint_control_low fields
    localparam int BIT_TOGGLE_RESET = 6;
    localparam int BIT_STALL_SENT = 5;
    localparam int BIT_STALL_REQUEST = 4;
    localparam int BIT_FLUSH = 3;
    localparam int BIT_UNDERRUN = 2;
    localparam int BIT_HAS_PACKET = 1;
    localparam int BIT_PACKET_LOADED = 0;
    // in_endpoint_control_high fields
    localparam int BIT_DOUBLE_BUFFER = 7;
    localparam int BIT_ISO_MODE = 6;
    localparam int BIT_FORCE_TOGGLE = 3;
    // iso config register field
    localparam int BIT_FRAME_DEFERRAL = 0;

    localparam logic [7:0] RST_CTRL_LOW = 8'h00;
    localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
    localparam logic [1:0] RST_INDEX = 2'h0;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    localparam logic [1:0] FIRST_EP = 2'h1;
    localparam logic [1:0] LAST_EP = 2'h3;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        UIECS_ANS_STALL = 4'h1,
        UIECS_ANS_DATA = 4'h2,
        UIECS_ANS_ZLP = 4'h4,
        UIECS_ANS_NAK = 4'h8
    } uiecs_answer_e;

    typedef struct packed {
        logic dbuf;
        logic iso;
        logic defer;
        logic force_toggle;
    } uiecs_cfg_s;

    typedef struct packed {
        logic valid;
        logic [1:0] ep;
    } uiecs_token_s;

    typedef struct packed {
        logic valid;
        logic [1:0] ep;
        uiecs_answer_e kind;
        logic toggle;
    } uiecs_resp_s;
endpackage
`default_nettype wire

/* uiecs_endpoint.sv */
`timescale 1ns/1ps
`default_nettype none
module uiecs_endpoint
    import uiecs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire uiecs_cfg_s cfg,
    input wire logic wr_low,
    input wire logic [7:0] wr_data,
    input wire logic token,
    input wire logic sof,
    input wire logic ack,
    output logic [7:0] rd_low,
    output uiecs_answer_e answer,
    output logic toggle,
    output logic irq_event
);
    logic [1:0] q;
    logic [1:0] fresh;
    logic [1:0] next_q;
    logic [1:0] next_fresh;
    logic [1:0] cap;
    logic loaded, committed, stall_req, stall_sent, underrun;
    logic deferring, eligible, commit, slot_open, set_loaded;
    logic send_data, do_flush, dec, stall_evt, under_evt;

    assign deferring = cfg.iso & cfg.defer;
    assign cap = cfg.dbuf ? 2'h2 : 2'h1;
    assign eligible = q > fresh; // [R15]
    assign commit = loaded & ~committed & (q < cap);
    assign slot_open = commit & cfg.dbuf & (q == 2'h0); // [R14]
    assign set_loaded = wr_low & wr_data[BIT_PACKET_LOADED] & ~loaded;
    assign stall_evt = token & stall_req; // [R3]
    assign send_data = token & ~stall_req & eligible;
    assign under_evt = token & ~stall_req & ~eligible;
    assign do_flush = wr_low & wr_data[BIT_FLUSH] & (q != 2'h0); // [R4]
    assign dec = send_data | do_flush;
    assign irq_event = send_data | stall_evt | do_flush; // [R11]

    always_comb begin
        if (stall_req) begin
            answer = UIECS_ANS_STALL; // [R3]
        end else if (eligible) begin
            answer = UIECS_ANS_DATA;
        end else if (cfg.iso) begin
            answer = UIECS_ANS_ZLP; // [R5]
        end else begin
            answer = UIECS_ANS_NAK; // [R6]
        end
    end

    always_comb begin
        next_q = 2'(q + {1'b0, commit} - {1'b0, dec});
        if (sof) begin
            next_fresh = 2'h0; // [R15]
        end else begin
            next_fresh = 2'(fresh + {1'b0, commit & deferring});
            if (next_fresh > next_q) begin
                next_fresh = next_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 2'h0;
            fresh <= 2'h0;
        end else begin
            q <= next_q;
            fresh <= next_fresh;
        end
    end

    // a queued packet stays loaded until a data packet is sent, unless double buffering queues it into an empty FIFO
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loaded <= 1'b0;
            committed <= 1'b0;
        end else if (set_loaded) begin
            loaded <= 1'b1;
            committed <= 1'b0;
        end else begin
            if (commit) begin
                committed <= 1'b1;
            end
            if (slot_open | (send_data & committed)) begin
                loaded <= 1'b0; // [R9]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_req <= 1'b0;
            stall_sent <= 1'b0;
            underrun <= 1'b0;
        end else begin
            if (wr_low) begin
                stall_req <= wr_data[BIT_STALL_REQUEST];
            end
            // hardware set wins over a software clear
            if (stall_evt) begin
                stall_sent <= 1'b1; // [R2]
            end else if (wr_low & ~wr_data[BIT_STALL_SENT]) begin
                stall_sent <= 1'b0;
            end
            if (under_evt) begin
                underrun <= 1'b1; // [R5] [R6]
            end else if (wr_low & ~wr_data[BIT_UNDERRUN]) begin
                underrun <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle <= 1'b0;
        end else if (wr_low & wr_data[BIT_TOGGLE_RESET]) begin
            toggle <= 1'b0; // [R1]
        end else if (cfg.force_toggle ? send_data : ack) begin
            toggle <= ~toggle;
        end
    end

    always_comb begin
        rd_low = RST_CTRL_LOW;
        rd_low[BIT_STALL_SENT] = stall_sent;
        rd_low[BIT_STALL_REQUEST] = stall_req;
        rd_low[BIT_UNDERRUN] = underrun;
        rd_low[BIT_HAS_PACKET] = q != 2'h0; // [R7]
        rd_low[BIT_PACKET_LOADED] = loaded & ~(deferring & (fresh != 2'h0)); // [R10]
    end

    a_stall_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        stall_evt |=> stall_sent && rd_low[BIT_STALL_SENT]) // [R2]
        else $error("stall sent flag not set");
    a_toggle_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_low && wr_data[BIT_TOGGLE_RESET] |=> !toggle) // [R1]
        else $error("data toggle not reset");
    a_flush_empties: assert property (@(posedge aclk) disable iff (!aresetn)
        do_flush && q == 2'h1 && !commit |=> !rd_low[BIT_HAS_PACKET]) // [R4][R7]
        else $error("flush left fifo not empty");
    a_nak_underrun: assert property (@(posedge aclk) disable iff (!aresetn)
        token && !stall_req && q == 2'h0 && !cfg.iso
        |-> answer == UIECS_ANS_NAK ##1 underrun) // [R6]
        else $error("nak without underrun");
    a_defer_frame: assert property (@(posedge aclk) disable iff (!aresetn)
        deferring && commit && q == 2'h0 && !sof && !dec
        |=> !eligible && !rd_low[BIT_PACKET_LOADED]) // [R15][R10]
        else $error("deferred packet eligible before sof");
endmodule
`default_nettype wire

/* uiecs_ctrl.sv */
// What this block does
// R1: writing toggle-reset clears data toggle, reads zero
// R2: stall handshake sent sets stall-sent flag
// R3: stall request answers IN tokens with STALL
// R4: flush write discards one queued packet
// R5: iso empty IN sends zero-length, sets underrun
// R6: bulk NAK to IN sets underrun flag
// R7: has-packet bit shows FIFO not empty
// R8: firmware sets packet-loaded after filling FIFO
// R9: loaded clears on transmit or open slot
// R10: deferred iso loaded reads zero until SOF
// R11: interrupt on data packet sent, stall sent or flush
// R12: control low at index 0x11, resets zero
// R13: index register selects mapped endpoint set
// R14: double-buffer bit enables second packet slot
// R15: deferred iso packets wait for next SOF
`timescale 1ns/1ps
`default_nettype none
module uiecs_ctrl
    import uiecs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire uiecs_token_s usb_token,
    input wire uiecs_token_s usb_ack,
    input wire logic usb_sof,
    output uiecs_resp_s usb_resp,
    output logic irq
);
    // ==========================================================
    // address decode helpers
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    function automatic logic is_endpoint(input logic [1:0] ep);
        is_endpoint = (ep >= FIRST_EP) && (ep <= LAST_EP);
    endfunction

    // ==========================================================
    // register state
    logic [1:0] index;
    logic [3:1] dbuf;
    logic [3:1] iso;
    logic [3:1] force_toggle;
    logic defer;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;

    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write, lane0;
    logic wr_index, wr_low, wr_high, wr_status, wr_mask, wr_iso_cfg;
    logic wr_mapped;

    logic [7:0] rd_low [3:1];
    uiecs_answer_e answer [3:1];
    logic [3:1] toggle;
    logic [3:1] ep_event;
    logic [3:1] ep_wr_low;
    logic [3:1] ep_token;
    logic [3:1] ep_ack;
    logic [31:0] rd_word;
    logic rd_mapped;

    // ==========================================================
    // axi4-lite write channel
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign lane0 = w_strb[0];

    // address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    assign wr_index = aw_addr == byte_addr(REG_INDEX_IDX);
    assign wr_low = aw_addr == byte_addr(REG_CTRL_LOW_IDX); // [R12]
    assign wr_high = aw_addr == byte_addr(REG_CTRL_HIGH_IDX);
    assign wr_status = aw_addr == byte_addr(REG_IRQ_STATUS_IDX);
    assign wr_mask = aw_addr == byte_addr(REG_IRQ_MASK_IDX);
    assign wr_iso_cfg = aw_addr == byte_addr(REG_ISO_CFG_IDX);
    assign wr_mapped = wr_index | wr_low | wr_high | wr_status | wr_mask
        | wr_iso_cfg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index <= RST_INDEX;
        end else if (do_write & lane0 & wr_index) begin
            index <= w_data[1:0];
        end
    end

    // only the indexed endpoint's set is reachable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbuf <= RST_CTRL_HIGH[3:1];
            iso <= RST_CTRL_HIGH[3:1];
            force_toggle <= RST_CTRL_HIGH[3:1];
        end else if (do_write & lane0 & wr_high & is_endpoint(index)) begin
            dbuf[index] <= w_data[BIT_DOUBLE_BUFFER]; // [R13] [R14]
            iso[index] <= w_data[BIT_ISO_MODE];
            force_toggle[index] <= w_data[BIT_FORCE_TOGGLE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            defer <= 1'b0;
            irq_mask <= RST_IRQ_MASK;
        end else if (do_write & lane0) begin
            if (wr_iso_cfg) begin
                defer <= w_data[BIT_FRAME_DEFERRAL];
            end
            if (wr_mask) begin
                irq_mask <= w_data[2:0];
            end
        end
    end

    // ==========================================================
    // endpoints 1 to 3
    genvar e;
    generate
        for (e = 1; e <= 3; e++) begin : g_ep
            uiecs_cfg_s cfg;
            assign cfg = '{dbuf: dbuf[e], iso: iso[e], defer: defer,
                force_toggle: force_toggle[e]};
            assign ep_wr_low[e] = do_write & lane0 & wr_low
                & (index == 2'(e)); // [R13]
            assign ep_token[e] = usb_token.valid & (usb_token.ep == 2'(e));
            assign ep_ack[e] = usb_ack.valid & (usb_ack.ep == 2'(e));
            uiecs_endpoint u_ep (
                .aclk(aclk),
                .aresetn(aresetn),
                .cfg(cfg),
                .wr_low(ep_wr_low[e]),
                .wr_data(w_data[7:0]),
                .token(ep_token[e]),
                .sof(usb_sof),
                .ack(ep_ack[e]),
                .rd_low(rd_low[e]),
                .answer(answer[e]),
                .toggle(toggle[e]),
                .irq_event(ep_event[e])
            );
        end
    endgenerate

    // ==========================================================
    // answer to the transmit engine, one cycle after the token
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_resp <= '{valid: 1'b0, ep: 2'h0, kind: UIECS_ANS_NAK,
                toggle: 1'b0};
        end else begin
            usb_resp.valid <= usb_token.valid & is_endpoint(usb_token.ep);
            if (usb_token.valid & is_endpoint(usb_token.ep)) begin
                usb_resp.ep <= usb_token.ep;
                usb_resp.kind <= answer[usb_token.ep]; // [R3] [R5] [R6]
                usb_resp.toggle <= toggle[usb_token.ep];
            end
        end
    end

    // ==========================================================
    // interrupt status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 3'h0;
        end else if (do_write & lane0 & wr_status) begin
            irq_status <= ep_event | (irq_status & ~w_data[2:0]); // [R11]
        end else begin
            irq_status <= irq_status | ep_event; // [R11]
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // axi4-lite read channel; reads have no side effects
    always_comb begin
        rd_word = 32'h0;
        rd_mapped = 1'b1;
        if (s_axi_araddr == byte_addr(REG_INDEX_IDX)) begin
            rd_word[1:0] = index;
        end else if (s_axi_araddr == byte_addr(REG_CTRL_LOW_IDX)) begin
            // bit 7 and toggle reset stay zero
            if (is_endpoint(index)) begin
                rd_word[7:0] = rd_low[index]; // [R12] [R1]
            end
        end else if (s_axi_araddr == byte_addr(REG_CTRL_HIGH_IDX)) begin
            if (is_endpoint(index)) begin
                rd_word[BIT_DOUBLE_BUFFER] = dbuf[index];
                rd_word[BIT_ISO_MODE] = iso[index];
                rd_word[BIT_FORCE_TOGGLE] = force_toggle[index];
            end
        end else if (s_axi_araddr == byte_addr(REG_IRQ_STATUS_IDX)) begin
            rd_word[2:0] = irq_status;
        end else if (s_axi_araddr == byte_addr(REG_IRQ_MASK_IDX)) begin
            rd_word[2:0] = irq_mask;
        end else if (s_axi_araddr == byte_addr(REG_ISO_CFG_IDX)) begin
            rd_word[BIT_FRAME_DEFERRAL] = defer;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    a_stall_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        usb_token.valid && is_endpoint(usb_token.ep)
        && rd_low[usb_token.ep][BIT_STALL_REQUEST]
        |=> usb_resp.valid && usb_resp.kind == UIECS_ANS_STALL) // [R3]
        else $error("stall request not answered with stall");
    a_ctrl_low_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr == byte_addr(REG_CTRL_LOW_IDX)
        |=> s_axi_rvalid && s_axi_rdata[7:6] == 2'h0
        && s_axi_rresp == AXI_OKAY) // [R12] [R1]
        else $error("control low read bits 7 or 6 not zero");
    a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
        |(ep_event & irq_mask) && !do_write |=> irq) // [R11]
        else $error("unmasked endpoint event gave no interrupt");
    a_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && !wr_mapped |=> s_axi_bvalid
        && s_axi_bresp == AXI_SLVERR)
        else $error("unmapped write not refused");
    a_index_select: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && lane0 && wr_high && index == 2'h2
        |=> dbuf[2] == $past(w_data[BIT_DOUBLE_BUFFER])
        && $stable(dbuf[1])) // [R13] [R14]
        else $error("control high written to wrong endpoint");
    a_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && lane0 && wr_status && w_data[0] && !ep_event[1]
        |=> !irq_status[0])
        else $error("status bit not cleared by write one");
endmodule
`default_nettype wire

/* uiecs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uiecs_host_model
    import uiecs_pkg::*;
(
    input wire logic aclk,
    input wire uiecs_resp_s usb_resp,
    output uiecs_token_s usb_token,
    output uiecs_token_s usb_ack,
    output logic usb_sof
);
    initial begin
        usb_token = '0;
        usb_ack = '0;
        usb_sof = 1'b0;
    end
    // ==========================================
    // host traffic, one token outstanding
    task automatic in_token(input logic [1:0] ep, output logic [3:0] k,
                            output logic tg);
        @(posedge aclk);
        usb_token <= '{1'b1, ep};
        @(posedge aclk);
        // released endpoint lines flip so a stale value is never seen
        usb_token <= '{1'b0, ~ep};
        @(posedge aclk);
        // an answer for the wrong endpoint counts as no answer
        k = (usb_resp.valid && usb_resp.ep == ep) ? usb_resp.kind : 4'h0;
        tg = usb_resp.toggle;
    endtask
    task automatic ack(input logic [1:0] ep);
        @(posedge aclk);
        usb_ack <= '{1'b1, ep};
        @(posedge aclk);
        usb_ack <= '{1'b0, ~ep};
    endtask
    task automatic sof();
        @(posedge aclk);
        usb_sof <= 1'b1;
        @(posedge aclk);
        usb_sof <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uiecs_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    failures++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, sof;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    uiecs_token_s tok, ack;
    uiecs_resp_s resp;
    int failures = 0;
    int comparisons = 0;
    always #2.5 aclk = ~aclk;
    uiecs_ctrl uiecs_ctrl_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .usb_token(tok),
        .usb_ack(ack), .usb_sof(sof), .usb_resp(resp), .irq(irq));
    uiecs_host_model uiecs_host_model_i (.aclk(aclk), .usb_resp(resp),
        .usb_token(tok), .usb_ack(ack), .usb_sof(sof));
    // ==========================================
    // bus helpers
    function automatic logic [7:0] ad(input logic [7:0] i);
        return {i[5:0], 2'b00};
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hang(input int n);
        if (n >= 50) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] er = AXI_OKAY);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= ad(i);
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        hang(n);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        hang(n);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] i, input logic [7:0] m,
                          input logic [7:0] e);
        logic [7:0] d;
        logic [1:0] r;
        rd(ad(i), d, r);
        `CHK(d & m, e)
        `CHK(r, AXI_OKAY)
    endtask
    task automatic tk(input logic [1:0] ep, input logic [3:0] ek,
                      input logic et);
        logic [3:0] k;
        logic t;
        uiecs_host_model_i.in_token(ep, k, t);
        `CHK(k, ek)
        `CHK(t, et)
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [7:0] d;
        logic [1:0] r;
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h00);
        rd(8'h04, d, r);
        `CHK(r, AXI_SLVERR)
        wr(8'h01, 8'h00, AXI_SLVERR);
        $display("test regs done");
    endtask
    task automatic t_bulk();
        wr(REG_INDEX_IDX, 8'h01);
        wr(REG_IRQ_MASK_IDX, 8'h07);
        tk(2'h1, UIECS_ANS_NAK, 1'b0);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h04);
        `CHK(irq, 1'b0)
        wr(REG_CTRL_LOW_IDX, 8'h00);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h00);
        wr(REG_CTRL_LOW_IDX, 8'h01);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h03);
        tk(2'h1, UIECS_ANS_DATA, 1'b0);
        `CHK(irq, 1'b1)
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h00);
        uiecs_host_model_i.ack(2'h1);
        wr(REG_IRQ_STATUS_IDX, 8'h01);
        `CHK(irq, 1'b0)
        $display("test bulk done");
    endtask
    task automatic t_stall();
        wr(REG_CTRL_LOW_IDX, 8'h10);
        tk(2'h1, UIECS_ANS_STALL, 1'b1);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h30);
        `CHK(irq, 1'b1)
        // toggle reset while dropping the sent flag
        wr(REG_CTRL_LOW_IDX, 8'h50);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h10);
        tk(2'h1, UIECS_ANS_STALL, 1'b0);
        wr(REG_CTRL_LOW_IDX, 8'h00);
        wr(REG_IRQ_STATUS_IDX, 8'h07);
        $display("test stall done");
    endtask
    task automatic t_dbuf();
        wr(REG_IRQ_MASK_IDX, 8'h00);
        wr(REG_INDEX_IDX, 8'h02);
        wr(REG_CTRL_HIGH_IDX, 8'h80);
        wr(REG_CTRL_LOW_IDX, 8'h01);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h02);
        wr(REG_CTRL_LOW_IDX, 8'h01);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h03);
        chk_rd(REG_IRQ_STATUS_IDX, 8'h07, 8'h00);
        wr(REG_INDEX_IDX, 8'h01);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h00);
        wr(REG_INDEX_IDX, 8'h02);
        wr(REG_CTRL_LOW_IDX, 8'h08);
        chk_rd(REG_CTRL_LOW_IDX, 8'h02, 8'h02);
        chk_rd(REG_IRQ_STATUS_IDX, 8'h07, 8'h02);
        `CHK(irq, 1'b0)
        wr(REG_CTRL_LOW_IDX, 8'h08);
        chk_rd(REG_CTRL_LOW_IDX, 8'h02, 8'h00);
        wr(REG_IRQ_STATUS_IDX, 8'h02);
        $display("test dbuf done");
    endtask
    task automatic t_iso();
        wr(REG_INDEX_IDX, 8'h03);
        // forced toggle: flips on every data packet, no ack needed
        wr(REG_CTRL_HIGH_IDX, 8'h48);
        wr(REG_ISO_CFG_IDX, 8'h01);
        tk(2'h3, UIECS_ANS_ZLP, 1'b0);
        chk_rd(REG_CTRL_LOW_IDX, 8'hff, 8'h04);
        wr(REG_CTRL_LOW_IDX, 8'h01);
        chk_rd(REG_CTRL_LOW_IDX, 8'h01, 8'h00);
        tk(2'h3, UIECS_ANS_ZLP, 1'b0);
        uiecs_host_model_i.sof();
        tk(2'h3, UIECS_ANS_DATA, 1'b0);
        tk(2'h3, UIECS_ANS_ZLP, 1'b1);
        $display("test iso done");
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_bulk();
        t_stall();
        t_dbuf();
        t_iso();
        tally_and_finish();
    end
endmodule
`default_nettype wire
